// *** spf_pkg.sv ***
// Purpose: shared types and constants of the serial remote-control port
// Assumes: single clock at 40 MHz, asynchronous active-low reset
// Notes:   baud figure is a plain default; the top module can override it
package spf_pkg;

	// ****************************************************************
	// clock and bit timing
	// ****************************************************************
	localparam int SPF_CLK_HZ      = 40000000;                 // system clock rate
	localparam int SPF_BAUD        = 9600;                     // default line rate
	localparam int SPF_BIT_CYCLES  = SPF_CLK_HZ / SPF_BAUD;    // clocks per bit

	// ****************************************************************
	// flow control characters and thresholds
	// ****************************************************************
	localparam logic [7:0] SPF_XON        = 8'h11;             // resume character
	localparam logic [7:0] SPF_XOFF       = 8'h13;             // pause character
	localparam logic [1:0] SPF_BUF_DEPTH  = 2'h2;              // receive buffer entries
	localparam logic [1:0] SPF_XOFF_LEVEL = 2'h1;              // fill that asks for pause
	localparam logic [1:0] SPF_XON_LEVEL  = 2'h0;              // fill that allows resume
	localparam logic [2:0] SPF_LAST_BIT7  = 3'h6;              // last data index, 7 bits
	localparam logic [2:0] SPF_LAST_BIT8  = 3'h7;              // last data index, 8 bits

	// ****************************************************************
	// values after reset
	// ****************************************************************
	localparam logic       SPF_LINE_IDLE  = 1'b1;              // marking level of txd
	localparam logic       SPF_HS_RST     = 1'b0;              // handshake outputs in reset

	// ****************************************************************
	// modes and states
	// ****************************************************************
	typedef enum logic [2:0] {
		SPF_PAR_NONE = 3'h0,
		SPF_PAR_EVEN = 3'h1,
		SPF_PAR_ODD  = 3'h2,
		SPF_PAR_ZERO = 3'h3,
		SPF_PAR_ONE  = 3'h4
	} spf_parity_t;

	typedef enum logic [1:0] {
		SPF_HS_OFF   = 2'h0,
		SPF_HS_ON    = 2'h1,
		SPF_HS_SPACE = 2'h2                                      // buffer_space_handshake
	} spf_hs_t;

	// gray codes along idle-start-data-parity-stop
	typedef enum logic [2:0] {
		SPF_ST_IDLE  = 3'h0,
		SPF_ST_START = 3'h1,
		SPF_ST_DATA  = 3'h3,
		SPF_ST_PAR   = 3'h2,
		SPF_ST_STOP  = 3'h6
	} spf_state_t;

	typedef struct packed {
		logic        word8;      // 1: eight data bits, 0: seven
		logic        stop2;      // 1: two stop bits
		spf_parity_t parity;     // parity choice
		logic        echo;       // send received characters back
		logic        tx_pace;    // obey far-end xon/xoff
		logic        rx_pace;    // emit xon/xoff
		spf_hs_t     rts_mode;   // rts/cts handshake mode
		spf_hs_t     dtr_mode;   // dtr/dsr handshake mode
		logic        balanced;   // balanced line variant selected
	} spf_cfg_t;

	typedef struct packed {
		logic [7:0] data;        // received character
		logic       par_err;     // parity mismatch
		logic       frame_err;   // stop bit seen low
	} spf_rx_word_t;

endpackage

// *** spf_serial_port.sv ***
// Purpose: async serial port with framing options, echo, xon/xoff and rts/dtr handshakes
// Assumes: one clock; line pins come from outside and are synchronised here
// Notes:   terminal-side role; two-entry receive buffer feeds the user side
// Overview of operation
// R1: seven or eight data bits, same both ends
// R2: one or two stop bits per character
// R3: parity even, odd, zero, one or none
// R4: echo returns received characters when enabled, except xon/xoff taken by tx_pace; newest unsent one only
// R5: transmit pacing switchable, obeys far-end xon/xoff
// R6: receive pacing switchable, regulates far end
// R7: rts off holds low, on holds high
// R8: rts space mode high while buffer has room
// R9: rts space mode: low cts stops transmitter
// R10: dtr off holds low, on holds high
// R11: dtr space mode high while buffer has room
// R12: dtr space mode: low dsr stops transmitter
// R13: balanced variant disables dtr/dsr handshake
// R14: device acts as terminal side of link
// R15: send xoff near full, xon when freed
// R16: xoff received suspends sending until xon
module spf_serial_port #(
	parameter int BIT_CYCLES = spf_pkg::SPF_BIT_CYCLES  // clocks per bit, shorten in sim
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire spf_pkg::spf_cfg_t cfg,
	input  wire logic              rxd,
	input  wire logic              cts,
	input  wire logic              dsr,
	output logic                   txd,
	output logic                   rts,
	output logic                   dtr,
	input  wire logic [7:0]        tx_data,
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	output spf_pkg::spf_rx_word_t  rx_word,
	output logic                   rx_valid,
	input  wire logic              rx_ready,
	output logic                   rx_overrun
);

	// ****************************************************************
	// timing constants
	// ****************************************************************
	localparam logic [15:0] BIT_END  = 16'(BIT_CYCLES - 1);      // last clock of a bit
	localparam logic [15:0] HALF_END = 16'(BIT_CYCLES / 2 - 1);  // middle of start bit

	// parity bit for a character under the given framing
	function automatic logic par_of(input logic [7:0] d, input logic w8,
	                                input spf_pkg::spf_parity_t p);
		logic x;
		x = w8 ? ^d : ^d[6:0];
		unique case (p)
			spf_pkg::SPF_PAR_EVEN: par_of = x;
			spf_pkg::SPF_PAR_ODD:  par_of = ~x;
			spf_pkg::SPF_PAR_ONE:  par_of = 1'b1;
			default:               par_of = 1'b0;
		endcase
	endfunction

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [2:0] pin_m_q;    // first stage, read only by second stage
	logic [2:0] pin_s_q;    // second stage: rxd, cts, dsr
	logic       rxd_s;
	logic       cts_s;
	logic       dsr_s;

	// two flops per pin, all from another domain
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_m_q <= 3'h7;
			pin_s_q <= 3'h7;
		end else begin
			pin_m_q <= {dsr, cts, rxd};
			pin_s_q <= pin_m_q;
		end
	end
	assign rxd_s = pin_s_q[0];
	assign cts_s = pin_s_q[1];
	assign dsr_s = pin_s_q[2];

	// ****************************************************************
	// receiver
	// ****************************************************************
	spf_pkg::spf_state_t rx_st_q;     // receive state
	logic [15:0]         rx_cnt_q;    // clocks within a bit
	logic [2:0]          rx_idx_q;    // data bit index
	logic [7:0]          rx_sh_q;     // shift register, lsb first
	logic                rx_pb_q;     // sampled parity bit
	logic                rx_done;     // stop bit sampled this cycle
	logic                rx_bit_end;
	logic [2:0]          rx_last;
	logic [7:0]          rx_char;
	logic                rx_perr;

	assign rx_bit_end = rx_cnt_q == BIT_END;
	assign rx_last    = cfg.word8 ? spf_pkg::SPF_LAST_BIT8 : spf_pkg::SPF_LAST_BIT7;  // [R1]
	assign rx_done    = (rx_st_q == spf_pkg::SPF_ST_STOP) && rx_bit_end;
	assign rx_char    = cfg.word8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};                  // [R1]
	assign rx_perr    = (cfg.parity != spf_pkg::SPF_PAR_NONE) &&
	                    (rx_pb_q != par_of(rx_char, cfg.word8, cfg.parity));         // [R3]

	// bit counter restarts at each state change
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_cnt_q <= 16'h0000;
		end else if (rx_st_q == spf_pkg::SPF_ST_IDLE || rx_bit_end ||
		             (rx_st_q == spf_pkg::SPF_ST_START && rx_cnt_q == HALF_END)) begin
			rx_cnt_q <= 16'h0000;
		end else begin
			rx_cnt_q <= rx_cnt_q + 16'h0001;
		end
	end

	// frame walk; second stop bit is left to the idle hunt
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_st_q  <= spf_pkg::SPF_ST_IDLE;
			rx_idx_q <= 3'h0;
			rx_sh_q  <= 8'h00;
			rx_pb_q  <= 1'b0;
		end else begin
			unique case (rx_st_q)
				spf_pkg::SPF_ST_IDLE: if (!rxd_s) begin
					rx_st_q <= spf_pkg::SPF_ST_START;
				end
				spf_pkg::SPF_ST_START: if (rx_cnt_q == HALF_END) begin
					// a short glitch is not a start bit
					rx_st_q  <= rxd_s ? spf_pkg::SPF_ST_IDLE : spf_pkg::SPF_ST_DATA;
					rx_idx_q <= 3'h0;
				end
				spf_pkg::SPF_ST_DATA: if (rx_bit_end) begin
					rx_sh_q  <= {rxd_s, rx_sh_q[7:1]};
					rx_idx_q <= rx_idx_q + 3'h1;
					if (rx_idx_q == rx_last) begin
						rx_st_q <= (cfg.parity == spf_pkg::SPF_PAR_NONE) ?
						           spf_pkg::SPF_ST_STOP : spf_pkg::SPF_ST_PAR;   // [R3]
					end
				end
				spf_pkg::SPF_ST_PAR: if (rx_bit_end) begin
					rx_pb_q <= rxd_s;
					rx_st_q <= spf_pkg::SPF_ST_STOP;
				end
				spf_pkg::SPF_ST_STOP: if (rx_bit_end) begin
					rx_st_q <= spf_pkg::SPF_ST_IDLE;
				end
				default: rx_st_q <= spf_pkg::SPF_ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// received character routing
	// ****************************************************************
	logic rx_is_flow;   // xon/xoff consumed by the transmitter pacing
	logic rx_push;
	logic xoff_seen_q;  // far end asked us to pause

	assign rx_is_flow = cfg.tx_pace &&
	                    (rx_char == spf_pkg::SPF_XON || rx_char == spf_pkg::SPF_XOFF);
	assign rx_push    = rx_done && !rx_is_flow;

	// pause latch; forgotten when pacing is turned off
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xoff_seen_q <= 1'b0;
		end else if (!cfg.tx_pace) begin
			xoff_seen_q <= 1'b0;
		end else if (rx_done && rx_char == spf_pkg::SPF_XOFF) begin
			xoff_seen_q <= 1'b1;                                                   // [R16]
		end else if (rx_done && rx_char == spf_pkg::SPF_XON) begin
			xoff_seen_q <= 1'b0;                                                   // [R16]
		end
	end

	// ****************************************************************
	// two-entry receive buffer
	// ****************************************************************
	spf_pkg::spf_rx_word_t buf_mem_q [2];   // entries
	logic                  buf_wr_q;        // write slot
	logic                  buf_rd_q;        // read slot
	logic [1:0]            buf_cnt_q;       // fill level
	logic                  buf_full;
	logic                  buf_in;
	logic                  buf_out;

	assign buf_full = buf_cnt_q == spf_pkg::SPF_BUF_DEPTH;
	assign buf_in   = rx_push && !buf_full;
	assign buf_out  = rx_valid && rx_ready;
	assign rx_valid = buf_cnt_q != 2'h0;
	assign rx_word  = buf_mem_q[buf_rd_q];

	// storage; a word arriving while full is dropped and flagged
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			buf_mem_q[0] <= '0;
			buf_mem_q[1] <= '0;
		end else if (buf_in) begin
			buf_mem_q[buf_wr_q] <= '{data: rx_char, par_err: rx_perr, frame_err: !rxd_s};
		end
	end

	// pointers and level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			buf_wr_q   <= 1'b0;
			buf_rd_q   <= 1'b0;
			buf_cnt_q  <= 2'h0;
			rx_overrun <= 1'b0;
		end else begin
			buf_wr_q   <= buf_wr_q ^ buf_in;
			buf_rd_q   <= buf_rd_q ^ buf_out;
			buf_cnt_q  <= buf_cnt_q + {1'b0, buf_in} - {1'b0, buf_out};
			rx_overrun <= rx_push && buf_full;
		end
	end

	// ****************************************************************
	// handshake outputs
	// ****************************************************************
	logic rts_d;
	logic dtr_d;
	logic hw_block;     // far end says stop
	logic pace_stop;    // xoff in force

	assign rts_d = (cfg.rts_mode == spf_pkg::SPF_HS_ON) ||                       // [R7]
	               (cfg.rts_mode == spf_pkg::SPF_HS_SPACE && !buf_full);         // [R8]
	// balanced line has no dtr/dsr pair, so dtr rests low
	assign dtr_d = !cfg.balanced &&                                              // [R13]
	               ((cfg.dtr_mode == spf_pkg::SPF_HS_ON) ||                      // [R10]
	                (cfg.dtr_mode == spf_pkg::SPF_HS_SPACE && !buf_full));       // [R11]
	assign hw_block = (cfg.rts_mode == spf_pkg::SPF_HS_SPACE && !cts_s) ||       // [R9]
	                  (!cfg.balanced && cfg.dtr_mode == spf_pkg::SPF_HS_SPACE &&
	                   !dsr_s);                                                  // [R12] [R13]
	assign pace_stop = cfg.tx_pace && xoff_seen_q;                               // [R5]

	// terminal-side outputs, registered
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rts <= spf_pkg::SPF_HS_RST;
			dtr <= spf_pkg::SPF_HS_RST;
		end else begin
			rts <= rts_d;                                                          // [R14]
			dtr <= dtr_d;                                                          // [R14]
		end
	end

	// ****************************************************************
	// pending control and echo characters
	// ****************************************************************
	logic       ctl_pend_q;   // xon/xoff waiting to go out
	logic [7:0] ctl_char_q;
	logic       sent_xoff_q;  // far end is paused by us
	logic       echo_pend_q;  // received character waiting to go back
	logic [7:0] echo_char_q;
	logic       tx_go;        // transmitter loads a character
	logic       sel_ctl;
	logic       sel_echo;
	logic       want_xoff;
	logic       want_xon;

	assign want_xoff = cfg.rx_pace && !sent_xoff_q && buf_cnt_q >= spf_pkg::SPF_XOFF_LEVEL;
	// xon goes out even if pacing was switched off meanwhile, else the far end stays stuck
	assign want_xon  = sent_xoff_q && buf_cnt_q <= spf_pkg::SPF_XON_LEVEL;

	// control request; a new one waits until the pending one is consumed
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctl_pend_q  <= 1'b0;
			ctl_char_q  <= 8'h00;
			sent_xoff_q <= 1'b0;
		end else if (!ctl_pend_q && want_xoff) begin
			ctl_pend_q  <= 1'b1;                                                   // [R6] [R15]
			ctl_char_q  <= spf_pkg::SPF_XOFF;
			sent_xoff_q <= 1'b1;
		end else if (!ctl_pend_q && want_xon) begin
			ctl_pend_q  <= 1'b1;                                                   // [R15]
			ctl_char_q  <= spf_pkg::SPF_XON;
			sent_xoff_q <= 1'b0;
		end else if (tx_go && sel_ctl) begin
			ctl_pend_q  <= 1'b0;
		end
	end

	// echo slot; one deep, a newer character replaces an unsent one
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			echo_pend_q <= 1'b0;
			echo_char_q <= 8'h00;
		end else if (rx_push && cfg.echo) begin
			echo_pend_q <= 1'b1;                                                   // [R4]
			echo_char_q <= rx_char;
		end else if (tx_go && sel_echo) begin
			echo_pend_q <= 1'b0;
		end
	end

	// ****************************************************************
	// transmitter
	// ****************************************************************
	spf_pkg::spf_state_t tx_st_q;
	logic [15:0]         tx_cnt_q;
	logic [2:0]          tx_idx_q;
	logic [7:0]          tx_sh_q;
	logic                tx_pb_q;     // parity bit of the frame
	logic                tx_w8_q;     // framing latched per character
	logic                tx_s2_q;
	logic                tx_par_q;    // parity bit present
	logic                tx_stopn_q;  // second stop bit in progress
	logic                tx_bit_end;
	logic                tx_idle;
	logic [7:0]          tx_char;

	assign tx_idle    = tx_st_q == spf_pkg::SPF_ST_IDLE;
	assign tx_bit_end = tx_cnt_q == BIT_END;
	// control characters ignore a received xoff but still honour cts/dsr
	assign sel_ctl    = ctl_pend_q;
	assign sel_echo   = !ctl_pend_q && echo_pend_q;
	assign tx_go      = tx_idle && !hw_block &&
	                    (ctl_pend_q || ((echo_pend_q || tx_valid) && !pace_stop)); // [R9] [R12] [R16]
	assign tx_ready   = tx_idle && !hw_block && !pace_stop && !ctl_pend_q && !echo_pend_q;
	assign tx_char    = sel_ctl ? ctl_char_q : (sel_echo ? echo_char_q : tx_data);

	// bit counter
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_cnt_q <= 16'h0000;
		end else if (tx_idle || tx_bit_end) begin
			tx_cnt_q <= 16'h0000;
		end else begin
			tx_cnt_q <= tx_cnt_q + 16'h0001;
		end
	end

	// frame walk; txd changes with the state so it comes from a flop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_st_q    <= spf_pkg::SPF_ST_IDLE;
			txd        <= spf_pkg::SPF_LINE_IDLE;
			tx_idx_q   <= 3'h0;
			tx_sh_q    <= 8'h00;
			tx_pb_q    <= 1'b0;
			tx_w8_q    <= 1'b0;
			tx_s2_q    <= 1'b0;
			tx_par_q   <= 1'b0;
			tx_stopn_q <= 1'b0;
		end else begin
			unique case (tx_st_q)
				spf_pkg::SPF_ST_IDLE: if (tx_go) begin
					tx_st_q  <= spf_pkg::SPF_ST_START;
					txd      <= 1'b0;                                                // [R14]
					tx_sh_q  <= tx_char;
					tx_pb_q  <= par_of(tx_char, cfg.word8, cfg.parity);            // [R3]
					tx_w8_q  <= cfg.word8;                                         // [R1]
					tx_s2_q  <= cfg.stop2;                                         // [R2]
					tx_par_q <= cfg.parity != spf_pkg::SPF_PAR_NONE;
					tx_idx_q <= 3'h0;
				end
				spf_pkg::SPF_ST_START: if (tx_bit_end) begin
					tx_st_q <= spf_pkg::SPF_ST_DATA;
					txd     <= tx_sh_q[0];
					tx_sh_q <= {1'b0, tx_sh_q[7:1]};
				end
				spf_pkg::SPF_ST_DATA: if (tx_bit_end) begin
					tx_idx_q <= tx_idx_q + 3'h1;
					if (tx_idx_q == (tx_w8_q ? spf_pkg::SPF_LAST_BIT8 : spf_pkg::SPF_LAST_BIT7)) begin
						tx_st_q    <= tx_par_q ? spf_pkg::SPF_ST_PAR : spf_pkg::SPF_ST_STOP;
						txd        <= tx_par_q ? tx_pb_q : 1'b1;
						tx_stopn_q <= 1'b0;
					end else begin
						txd     <= tx_sh_q[0];
						tx_sh_q <= {1'b0, tx_sh_q[7:1]};
					end
				end
				spf_pkg::SPF_ST_PAR: if (tx_bit_end) begin
					tx_st_q <= spf_pkg::SPF_ST_STOP;
					txd     <= 1'b1;
				end
				spf_pkg::SPF_ST_STOP: if (tx_bit_end) begin
					tx_stopn_q <= 1'b1;
					if (!tx_s2_q || tx_stopn_q) begin
						tx_st_q <= spf_pkg::SPF_ST_IDLE;                               // [R2]
					end
				end
				default: begin
					tx_st_q <= spf_pkg::SPF_ST_IDLE;
					txd     <= 1'b1;
				end
			endcase
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence s_tx_load;
		tx_idle && tx_go ##1 tx_st_q == spf_pkg::SPF_ST_START;
	endsequence

	sequence s_start_low;
		!txd [*8];
	endsequence

	a_start_bit_low: assert property (@(posedge clk) disable iff (!nrst)  // [R14]
		s_tx_load |-> s_start_low)
		else $error("start bit not held low");

	a_rts_off_on: assert property (@(posedge clk) disable iff (!nrst)  // [R7]
		cfg.rts_mode != spf_pkg::SPF_HS_SPACE |=> rts == $past(cfg.rts_mode == spf_pkg::SPF_HS_ON))
		else $error("rts does not follow fixed mode");

	a_rts_space_full: assert property (@(posedge clk) disable iff (!nrst)  // [R8]
		cfg.rts_mode == spf_pkg::SPF_HS_SPACE |=> rts == !$past(buf_full))
		else $error("rts does not track buffer room");

	a_dtr_space_mode: assert property (@(posedge clk) disable iff (!nrst)  // [R11]
		!cfg.balanced && cfg.dtr_mode == spf_pkg::SPF_HS_SPACE |=> dtr == !$past(buf_full))
		else $error("dtr does not track buffer room");

	a_dtr_balanced_low: assert property (@(posedge clk) disable iff (!nrst)  // [R13]
		cfg.balanced |=> !dtr)
		else $error("dtr driven on balanced line");

	a_hw_hold_tx: assert property (@(posedge clk) disable iff (!nrst)  // [R9] [R12]
		tx_idle && hw_block |=> tx_idle)
		else $error("frame started while far end holds off");

	// watches the frame walk itself, not only the load term
	a_xoff_hold_tx: assert property (@(posedge clk) disable iff (!nrst)  // [R16]
		tx_idle && pace_stop && !ctl_pend_q |=> tx_idle)
		else $error("data sent during xoff");

	a_echo_capture: assert property (@(posedge clk) disable iff (!nrst)  // [R4]
		rx_push && cfg.echo |=> echo_pend_q && echo_char_q == $past(rx_char))
		else $error("received character not queued for echo");

	a_xoff_request: assert property (@(posedge clk) disable iff (!nrst)  // [R15]
		!ctl_pend_q && want_xoff |=> ctl_pend_q && ctl_char_q == spf_pkg::SPF_XOFF)
		else $error("xoff not requested near full");

	a_stop_bit_high: assert property (@(posedge clk) disable iff (!nrst)  // [R2]
		tx_st_q == spf_pkg::SPF_ST_STOP |-> txd)
		else $error("stop bit not high");

endmodule

// *** spf_host_model.sv ***
// Purpose: remote host on the serial line, the far end of the port
// Assumes: B clocks per bit and the same framing as the port
// Notes:   frames seen on txd are queued for the bench to compare
module spf_host_model #(
	parameter int B = 8                          // clocks per bit
) (
	input  wire logic              clk,
	input  wire spf_pkg::spf_cfg_t cfg,
	input  wire logic              txd,
	output logic                   rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];                          // data seen on txd
	logic       gpar[$];                         // parity bits seen on txd
	initial rxd = 1'b1;                          // marking while idle
	// parity bit of a character
	function automatic logic pbit(input logic [7:0] c);
		logic p;
		p = ^(cfg.word8 ? c : {1'b0, c[6:0]});
		case (cfg.parity)
			spf_pkg::SPF_PAR_ODD:  pbit = !p;
			spf_pkg::SPF_PAR_ZERO: pbit = 1'b0;
			spf_pkg::SPF_PAR_ONE:  pbit = 1'b1;
			default:               pbit = p;
		endcase
	endfunction
	// one frame lsb first, framing as configured
	task automatic send(input logic [7:0] c);
		logic q[$];
		q = {1'b0};
		for (int i = 0; i < (cfg.word8 ? 8 : 7); i++) q.push_back(c[i]);
		if (cfg.parity != spf_pkg::SPF_PAR_NONE) q.push_back(pbit(c));
		q.push_back(1'b1);
		if (cfg.stop2) q.push_back(1'b1);
		foreach (q[i]) begin
			rxd <= q[i];
			repeat (B) @(posedge clk);
		end
	endtask
	// sample txd mid bit; the stop bit is waited out, not judged
	initial forever begin
		logic [7:0] d;
		@(negedge txd);
		d = 8'h00;
		repeat (B / 2) @(posedge clk);
		for (int i = 0; i < (cfg.word8 ? 8 : 7); i++) begin
			repeat (B) @(posedge clk);
			d[i] = txd;
		end
		if (cfg.parity != spf_pkg::SPF_PAR_NONE) begin
			repeat (B) @(posedge clk);
			gpar.push_back(txd);
		end
		repeat (B) @(posedge clk);
		got.push_back(d);
	end
endmodule

// *** tb.sv ***
// Purpose: self-checking bench of the serial port
// Assumes: 40 MHz clock, bit time cut to 8 clocks
// Notes:   host model plays the far end; every wait is bounded
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int B = 8;                        // short bit time keeps the run brief
	logic                  clk, nrst, rxd, cts, dsr, txd, rts, dtr, rx_overrun;
	logic                  tx_valid, tx_ready, rx_valid, rx_ready;
	logic [7:0]            tx_data, c;
	spf_pkg::spf_cfg_t     cfg;
	spf_pkg::spf_rx_word_t rx_word;
	int                    miscompares, samples_checked, seed, ovr;
	always #12.5 clk = ~clk;
	// count dropped-character pulses; each stands for one cycle only
	always @(posedge clk) if (rx_overrun === 1'b1) ovr++;
	spf_serial_port #(.BIT_CYCLES(B)) dut (
		.clk(clk), .nrst(nrst), .cfg(cfg), .rxd(rxd), .cts(cts), .dsr(dsr),
		.txd(txd), .rts(rts), .dtr(dtr), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_overrun(rx_overrun));
	spf_host_model #(.B(B)) host (.clk(clk), .cfg(cfg), .txd(txd), .rxd(rxd));
	// ****************************************************************
	// checking helpers
	// ****************************************************************
	task automatic conclude();
		if (miscompares == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic hang();
		miscompares++;
		conclude();
	endtask
	// character as the port frames it
	function automatic logic [7:0] m(input logic [7:0] v);
		m = cfg.word8 ? v : {1'b0, v[6:0]};
	endfunction
	// wait for the host to collect one frame
	task automatic wgot(input logic [7:0] e);
		for (int k = 0; k < 40 * B && host.got.size() == 0; k++) @(posedge clk);
		if (host.got.size() == 0) hang();
		chk("txd char", 10'(host.got.pop_front()), 10'(e));
	endtask
	// offer one character, release after the taking edge
	task automatic put(input logic [7:0] v);
		tx_data <= v;
		tx_valid <= 1'b1;
		for (int k = 0; k < 40 * B; k++) begin
			@(negedge clk);
			if (tx_ready === 1'b1) break;
		end
		if (tx_ready !== 1'b1) hang();
		@(posedge clk);
		tx_valid <= 1'b0;
	endtask
	// check and pop the buffer head
	task automatic pop(input logic [7:0] e);
		for (int k = 0; k < 40 * B; k++) begin
			@(negedge clk);
			if (rx_valid === 1'b1) break;
		end
		if (rx_valid !== 1'b1) hang();
		chk("rx word", rx_word, {e, 2'b00});
		@(posedge clk);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
	endtask
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		seed = 32'hd2e5;
		clk = 1'b0;
		nrst = 1'b0;
		{cts, dsr, tx_valid, rx_ready, tx_data} = {4'hC, 8'h00};
		cfg = '0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		chk("txd idle", 10'(txd), 10'h1);
		for (int i = 0; i < 2; i++) begin
			cfg.rts_mode <= spf_pkg::spf_hs_t'(i);
			cfg.dtr_mode <= spf_pkg::spf_hs_t'(1 - i);
			repeat (3) @(posedge clk);
			chk("rts level", 10'(rts), 10'(i));
			chk("dtr level", 10'(dtr), 10'(1 - i));
		end
		// every parity choice, random character, size and stops from the index, both directions
		for (int p = 0; p < 5; p++) begin
			c = 8'($random(seed));
			cfg.parity <= spf_pkg::spf_parity_t'(p);
			// walk all four size and stop pairs from the low bits of p
			{cfg.word8, cfg.stop2} <= 2'(p);
			@(posedge clk);
			put(c);
			wgot(m(c));
			if (p > 0) chk("par bit", 10'(host.gpar.pop_front()), 10'(host.pbit(c)));
			host.send(c);
			pop(m(c));
			// long enough for a wrongly echoed frame to reach the host
			repeat (12 * B) @(posedge clk);
			chk("no echo", 10'(host.got.size()), 10'h0);
		end
		cfg.word8 <= 1'b1;
		cfg.parity <= spf_pkg::SPF_PAR_NONE;
		cfg.echo <= 1'b1;
		@(posedge clk);
		host.send(c);
		wgot(c);
		pop(c);
		cfg.echo <= 1'b0;
		// fill the buffer and send one more; the host ignores rts/dtr, so the third is dropped
		cfg.rts_mode <= spf_pkg::SPF_HS_SPACE;
		cfg.dtr_mode <= spf_pkg::SPF_HS_SPACE;
		@(posedge clk);
		host.send(8'h41);
		host.send(8'h42);
		host.send(8'h43);
		repeat (4) @(posedge clk);
		chk("rts full", 10'(rts), 10'h0);
		chk("dtr full", 10'(dtr), 10'h0);
		chk("overrun", 10'(ovr), 10'h1);
		pop(8'h41);
		repeat (3) @(posedge clk);
		chk("rts room", 10'(rts), 10'h1);
		chk("dtr room", 10'(dtr), 10'h1);
		pop(8'h42);
		cfg.balanced <= 1'b1;
		dsr <= 1'b0;
		repeat (4) @(posedge clk);
		chk("dtr bal", 10'(dtr), 10'h0);
		put(c);
		wgot(c);
		cfg.balanced <= 1'b0;
		// far end pauses the port by cts, then by dsr
		for (int i = 0; i < 2; i++) begin
			c = 8'($random(seed));
			cfg.rts_mode <= spf_pkg::spf_hs_t'(i ? 0 : 2);
			cfg.dtr_mode <= spf_pkg::spf_hs_t'(i ? 2 : 0);
			{cts, dsr} <= i ? 2'b10 : 2'b01;
			repeat (4) @(posedge clk);
			tx_data <= c;
			tx_valid <= 1'b1;
			repeat (12 * B) @(posedge clk);
			chk("held", 10'(host.got.size()), 10'h0);
			{cts, dsr} <= 2'b11;
			put(c);
			wgot(c);
		end
		cfg.tx_pace <= 1'b1;
		@(posedge clk);
		host.send(spf_pkg::SPF_XOFF);
		tx_valid <= 1'b1;
		repeat (12 * B) @(posedge clk);
		chk("paused", 10'(host.got.size()), 10'h0);
		// the offer stands while xon arrives, so exactly one frame is taken
		fork
			host.send(spf_pkg::SPF_XON);
			put(c);
		join
		wgot(c);
		chk("ctl kept", 10'(rx_valid), 10'h0);
		cfg.tx_pace <= 1'b0;
		cfg.rx_pace <= 1'b1;
		@(posedge clk);
		host.send(c);
		wgot(spf_pkg::SPF_XOFF);
		pop(c);
		wgot(spf_pkg::SPF_XON);
		conclude();
	end
endmodule
